// ==== verilog/rsc_parser.sv ====
// Text command interpreter for an RF source module, with AHB-Lite status.
// Assumes one 100 MHz clock, an AHB-Lite master and a host on the UART pins.
// Function
// RULE_01: UART at 115200 baud, no parity, one stop
// RULE_02: Reset: internal oscillator, off, 2450 MHz, 31.75 dB
// RULE_03: Frequency command stores frequency, replies name, channel, OK
// RULE_04: Power command stores watt setpoint, replies OK
// RULE_05: Enable command flag 1 enables, 0 disables
// RULE_06: Source command: 0 internal, 1 external input
// RULE_07: External input: oscillator off, attenuator 0 dB
// RULE_08: External selects feed-forward; internal restores gain control
// RULE_09: Every source command switches amplifier enable off
// RULE_10: Attenuation command sets attenuator level any time
// RULE_11: Host sets frequency to match external input
// RULE_12: Comma-separated line, dollar name, parsed whole first
// RULE_13: Bad name or range leaves settings unchanged
`timescale 1ns/1ps
`default_nettype none
module rsc_parser
  import rsc_pkg::*;
#(
  parameter logic [31:0] PWR_MAX_W = 32'h0000_0032, // Highest setpoint, W
  parameter int unsigned BIT_N     = BIT_CYC        // Cycles per serial bit
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link to the host
  input  wire logic        uart_rxd,
  output logic             uart_txd,
  // RF path controls
  output logic             src_ext,
  output logic             osc_on,
  output logic             amp_en,
  output logic             pa_ffwd,
  output logic [6:0]       atten_qdb,
  output logic [11:0]      freq_mhz,
  output logic [7:0]       power_w
);
  // Parser registers
  rsc_pst_t    pst_r, pst_nxt;   // Line state
  logic [31:0] name_r;           // Name letters, last one lowest
  logic [2:0]  nlen_r;           // Letters held
  logic [23:0] chan_r;           // Channel digits, echoed back
  logic [1:0]  clen_r;           // Channel digits held
  logic [31:0] arg_r;            // Argument value
  logic [3:0]  adig_r;           // Argument digits held
  logic [3:0]  ridx_r;           // Reply character index
  // Settings and bus-side registers
  logic        ctrl_en_r;        // Software gate on new lines
  logic        src_ext_r, osc_on_r, amp_en_r, pa_ffwd_r;
  logic [6:0]  att_r;            // Attenuation, quarter dB
  logic [11:0] freq_r;           // Frequency, MHz
  logic [7:0]  pwr_r;            // Power setpoint, W
  logic [15:0] ok_cnt_r;         // Commands carried out
  logic [15:0] bad_cnt_r;        // Lines thrown away
  logic        wr_pend_r;        // Write data phase pending
  logic [7:0]  wa_r;             // Write address
  logic [31:0] hrdata_r;         // Read data for the data phase
  // UART byte streams
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        tx_ready;
  logic [7:0]  tx_char;

  rsc_uart #(.BIT_N(BIT_N)) u_uart (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rxd      (uart_rxd),
    .txd      (uart_txd),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .tx_data  (tx_char),
    .tx_valid (pst_r == P_REPLY),
    .tx_ready (tx_ready)
  );

  // Character classes
  wire logic rx_dig   = rx_data >= 8'h30 && rx_data <= 8'h39;
  wire logic rx_let   = rx_data >= 8'h41 && rx_data <= 8'h5A;
  wire logic rx_blank = rx_data == CH_CR || rx_data == CH_SP;
  wire logic in_field = pst_r inside {P_NAME, P_CHAN, P_ARG};
  wire logic take_let = pst_r == P_NAME && rx_let && nlen_r < NAME_MAX;
  wire logic take_cd  = pst_r == P_CHAN && rx_dig && clen_r < CHAN_MAX;
  wire logic take_ad  = pst_r == P_ARG && rx_dig && adig_r < ARG_MAX;
  wire logic [3:0]  rx_val = rx_data[3:0];
  wire logic [31:0] arg_x10 = {arg_r[28:0], 3'b000} + {arg_r[30:0], 1'b0};

  // Command decode with range checks [RULE_06] [RULE_13]
  wire logic is_freq = name_r == NM_FREQ;
  wire logic is_pwr  = name_r == NM_PWR;
  wire logic is_en   = name_r == NM_EN;
  wire logic is_src  = name_r == NM_SRC;
  wire logic is_att  = name_r == NM_ATT;
  wire logic in_exec = pst_r == P_EXEC;
  wire logic do_freq = in_exec && is_freq && arg_r >= FREQ_MIN
                       && arg_r <= FREQ_MAX;
  wire logic do_pwr  = in_exec && is_pwr && arg_r <= PWR_MAX_W;
  wire logic do_en   = in_exec && is_en && arg_r <= FLAG_MAX;
  wire logic do_src  = in_exec && is_src && arg_r <= FLAG_MAX;
  wire logic do_att  = in_exec && is_att && arg_r <= ATT_MAX;
  wire logic cmd_ok  = do_freq || do_pwr || do_en || do_src || do_att;
  wire logic bad_evt = (in_field && pst_nxt inside {P_IDLE, P_SKIP})
                       || (in_exec && !cmd_ok);

  // Reply layout: $ name , channel , O K CR LF [RULE_03] [RULE_12]
  wire logic [3:0] p1   = {1'b0, nlen_r} + 4'h1;
  wire logic [3:0] p2   = p1 + {2'b00, clen_r} + 4'h1;
  wire logic [3:0] tail = ridx_r - p2;
  wire logic       last = ridx_r == p2 + 4'h4;
  wire logic [1:0] nsel = 2'({1'b0, nlen_r} - ridx_r);
  wire logic [1:0] csel = 2'(p2 - 4'h1 - ridx_r);
  wire logic [7:0] name_ch = 8'(name_r >> {nsel, 3'b000});
  wire logic [7:0] chan_ch = 8'(chan_r >> {csel, 3'b000});
  wire logic [7:0] tail_ch = tail == 4'h1 ? CH_O :
                             tail == 4'h2 ? CH_K :
                             tail == 4'h3 ? CH_CR : CH_LF;
  assign tx_char = ridx_r == 4'h0 ? CH_DOLLAR :
                   ridx_r < p1    ? name_ch :
                   ridx_r == p1   ? CH_COMMA :
                   ridx_r < p2    ? chan_ch :
                   ridx_r == p2   ? CH_COMMA : tail_ch;

  // Next line state; bytes arriving during execute or reply are dropped
  always_comb begin
    pst_nxt = pst_r;
    case (pst_r)
      P_IDLE: begin
        if (rx_valid && rx_data == CH_DOLLAR && ctrl_en_r) begin
          pst_nxt = P_NAME;  // [RULE_12]
        end
      end
      P_NAME, P_CHAN, P_ARG: begin
        if (rx_valid && !rx_blank) begin
          if (rx_data == CH_LF) begin
            // Act only on a complete line [RULE_12]
            pst_nxt = (pst_r == P_ARG && adig_r != 4'h0) ? P_EXEC : P_IDLE;
          end else if (rx_data == CH_COMMA) begin
            if (pst_r == P_NAME && nlen_r != 3'h0) begin
              pst_nxt = P_CHAN;
            end else if (pst_r == P_CHAN && clen_r != 2'h0) begin
              pst_nxt = P_ARG;
            end else begin
              pst_nxt = P_SKIP;  // [RULE_13]
            end
          end else if (!(take_let || take_cd || take_ad)) begin
            pst_nxt = P_SKIP;  // [RULE_13]
          end
        end
      end
      P_SKIP: begin
        if (rx_valid && rx_data == CH_LF) begin
          pst_nxt = P_IDLE;
        end
      end
      P_EXEC: begin
        pst_nxt = cmd_ok ? P_REPLY : P_IDLE;  // [RULE_13]
      end
      P_REPLY: begin
        if (tx_ready && last) begin
          pst_nxt = P_IDLE;
        end
      end
      default: pst_nxt = P_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r <= P_IDLE;
    end else begin
      pst_r <= pst_nxt;
    end
  end

  // Field collection; everything is cleared while waiting for a line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      name_r <= 32'h0000_0000;
      nlen_r <= 3'h0;
      chan_r <= 24'h00_0000;
      clen_r <= 2'h0;
      arg_r  <= 32'h0000_0000;
      adig_r <= 4'h0;
    end else if (pst_r == P_IDLE) begin
      name_r <= 32'h0000_0000;
      nlen_r <= 3'h0;
      chan_r <= 24'h00_0000;
      clen_r <= 2'h0;
      arg_r  <= 32'h0000_0000;
      adig_r <= 4'h0;
    end else if (rx_valid && take_let) begin
      name_r <= {name_r[23:0], rx_data};
      nlen_r <= nlen_r + 3'h1;
    end else if (rx_valid && take_cd) begin
      chan_r <= {chan_r[15:0], rx_data};
      clen_r <= clen_r + 2'h1;
    end else if (rx_valid && take_ad) begin
      arg_r  <= arg_x10 + {28'h000_0000, rx_val};
      adig_r <= adig_r + 4'h1;
    end
  end

  // Reply index walks one character per accepted byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ridx_r <= 4'h0;
    end else if (pst_r != P_REPLY) begin
      ridx_r <= 4'h0;
    end else if (tx_ready) begin
      ridx_r <= ridx_r + 4'h1;
    end
  end

  // RF settings; only a fully checked command touches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_ext_r <= 1'b0;       // [RULE_02]
      osc_on_r  <= 1'b0;       // [RULE_02]
      amp_en_r  <= 1'b0;       // [RULE_02]
      pa_ffwd_r <= 1'b0;
      att_r     <= RST_ATT;    // [RULE_02]
      freq_r    <= RST_FREQ;   // [RULE_02]
      pwr_r     <= RST_POWER;
    end else begin
      if (do_freq) begin
        freq_r <= arg_r[11:0];  // [RULE_03] [RULE_11]
      end
      if (do_pwr) begin
        pwr_r <= arg_r[7:0];  // [RULE_04]
      end
      if (do_en) begin
        amp_en_r <= arg_r[0];  // [RULE_05]
        // The oscillator only runs as a source, never with external input
        if (!src_ext_r) begin
          osc_on_r <= arg_r[0];
        end
      end
      if (do_src) begin
        src_ext_r <= arg_r[0];  // [RULE_06]
        pa_ffwd_r <= arg_r[0];  // [RULE_08]
        amp_en_r  <= 1'b0;      // [RULE_09]
        osc_on_r  <= 1'b0;      // [RULE_07]
        if (arg_r[0]) begin
          att_r <= 7'h00;  // [RULE_07]
        end
      end
      if (do_att) begin
        att_r <= arg_r[6:0];  // [RULE_10]
      end
    end
  end

  // Activity counters, wrapping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ok_cnt_r  <= 16'h0000;
      bad_cnt_r <= 16'h0000;
    end else begin
      ok_cnt_r  <= ok_cnt_r + {15'h0, cmd_ok};
      bad_cnt_r <= bad_cnt_r + {15'h0, bad_evt};
    end
  end

  // AHB-Lite: zero wait states, always OKAY, word transfers only
  wire logic ahb_go  = hsel && hready && htrans[1];
  wire logic wr_ctrl = wr_pend_r && wa_r == A_CTRL;
  // A read right behind a control write sees the new value
  wire logic ctrl_now = wr_ctrl ? hwdata[0] : ctrl_en_r;
  wire logic [31:0] stat_w = {27'h0, pst_r == P_REPLY, pa_ffwd_r,
                              amp_en_r, osc_on_r, src_ext_r};
  wire logic [31:0] rd_mux =
    haddr[7:0] == A_CTRL  ? {31'h0, ctrl_now} :
    haddr[7:0] == A_STAT  ? stat_w :
    haddr[7:0] == A_FREQ  ? {20'h0_0000, freq_r} :
    haddr[7:0] == A_POWER ? {24'h00_0000, pwr_r} :
    haddr[7:0] == A_ATTEN ? {25'h0, att_r} :
    haddr[7:0] == A_COUNT ? {bad_cnt_r, ok_cnt_r} : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Address phase capture and read data load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= ahb_go && hwrite;
      wa_r      <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_r <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_en_r <= hwdata[0];
    end
  end

  assign src_ext   = src_ext_r;
  assign osc_on    = osc_on_r;
  assign amp_en    = amp_en_r;
  assign pa_ffwd   = pa_ffwd_r;
  assign atten_qdb = att_r;
  assign freq_mhz  = freq_r;
  assign power_w   = pwr_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence reply_open;
    pst_r == P_REPLY && tx_char == CH_DOLLAR;
  endsequence
  sequence good_exec;
    in_exec && cmd_ok;
  endsequence

  freq_store_a: assert property (do_freq |=> freq_r == $past(arg_r[11:0])) // [RULE_03]
    else $error("frequency not stored");
  power_store_a: assert property (do_pwr |=> power_w == $past(arg_r[7:0])) // [RULE_04]
    else $error("power setpoint not stored");
  enable_flag_a: assert property (do_en |=> amp_en == $past(arg_r[0])) // [RULE_05]
    else $error("enable flag not applied");
  amp_config_a: assert property (do_src && arg_r[0] |=> src_ext && !osc_on && atten_qdb == 7'h00) // [RULE_07]
    else $error("amplifier configuration incomplete");
  ffwd_mode_a: assert property (pa_ffwd == src_ext) // [RULE_08]
    else $error("gain mode does not follow source");
  src_clears_a: assert property (do_src |=> !amp_en) // [RULE_09]
    else $error("enable not cleared by source command");
  att_store_a: assert property (do_att |=> atten_qdb == $past(arg_r[6:0])) // [RULE_10]
    else $error("attenuation not stored");
  reject_hold_a: assert property (in_exec && !cmd_ok |=> $stable(freq_mhz) && $stable(atten_qdb) && $stable(amp_en) && pst_r == P_IDLE) // [RULE_13]
    else $error("rejected line changed settings");
  reply_start_a: assert property (good_exec |=> reply_open) // [RULE_12]
    else $error("reply does not open with dollar");
endmodule // rsc_parser
`default_nettype wire

// ==== verilog/rsc_pkg.sv ====
// Shared constants for the RF source command parser: UART timing, register
// map, reset settings, ASCII codes, command names and parser states.
// Assumes a single 100 MHz clock feeding every module that imports it.
`default_nettype none
package rsc_pkg;
  // Clock and serial rate; the bit period rounds to the nearest cycle
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned BAUD     = 115_200;
  localparam int unsigned BIT_CYC  = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned CNT_W    = $clog2(BIT_CYC);
  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_FREQ  = 8'h08;
  localparam logic [7:0] A_POWER = 8'h0C;
  localparam logic [7:0] A_ATTEN = 8'h10;
  localparam logic [7:0] A_COUNT = 8'h14;
  // Status field positions
  localparam int unsigned ST_SRC  = 0;
  localparam int unsigned ST_OSC  = 1;
  localparam int unsigned ST_EN   = 2;
  localparam int unsigned ST_FFWD = 3;
  localparam int unsigned ST_BUSY = 4;
  // Values after reset: 2450 MHz, 31.75 dB in quarter-dB steps
  localparam logic        RST_CTRL  = 1'b1;
  localparam logic [11:0] RST_FREQ  = 12'h992;
  localparam logic [6:0]  RST_ATT   = 7'h7F;
  localparam logic [7:0]  RST_POWER = 8'h00;
  // Argument limits
  localparam logic [31:0] FREQ_MIN = 32'h0000_0960;
  localparam logic [31:0] FREQ_MAX = 32'h0000_09C4;
  localparam logic [31:0] ATT_MAX  = 32'h0000_007F;
  localparam logic [31:0] FLAG_MAX = 32'h0000_0001;
  // Field length limits
  localparam logic [2:0] NAME_MAX = 3'h4;
  localparam logic [1:0] CHAN_MAX = 2'h3;
  localparam logic [3:0] ARG_MAX  = 4'h9;
  // ASCII codes
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_SP     = 8'h20;
  localparam logic [7:0] CH_O      = 8'h4F;
  localparam logic [7:0] CH_K      = 8'h4B;
  // Command names, letters packed right-aligned
  localparam logic [31:0] NM_FREQ = 32'h0046_4353;
  localparam logic [31:0] NM_PWR  = 32'h5057_5253;
  localparam logic [31:0] NM_EN   = 32'h0045_4353;
  localparam logic [31:0] NM_SRC  = 32'h5246_5353;
  localparam logic [31:0] NM_ATT  = 32'h0047_4353;
  // Line parser states
  typedef enum logic [2:0] {
    P_IDLE, P_NAME, P_CHAN, P_ARG, P_SKIP, P_EXEC, P_REPLY
  } rsc_pst_t;
endpackage
`default_nettype wire

// ==== verilog/rsc_uart.sv ====
// Byte-wide UART receiver and transmitter, 8 data bits, no parity, one stop.
// Assumes the receive pin is asynchronous; it is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module rsc_uart
  import rsc_pkg::*;
#(
  parameter int unsigned BIT_N = BIT_CYC  // Clock cycles per serial bit
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Serial pins
  input  wire logic       rxd,
  output logic            txd,
  // Received bytes
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  // Bytes to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  localparam int unsigned HALF_N = BIT_N / 2;      // Start bit mid-point
  localparam int unsigned CW     = $clog2(BIT_N);  // Bit timer width
  logic             rxd_m_r, rxd_s_r;  // Two-stage synchroniser
  logic             rx_busy_r;         // Frame in progress
  logic [CW-1:0]    rx_cnt_r;          // Cycles to next sample
  logic [3:0]       rx_bit_r;          // 0 start, 1..8 data, 9 stop
  logic [7:0]       rx_sh_r;           // Data shifter, LSB first
  logic [9:0]       tx_sh_r;           // Stop, data, start; idles high
  logic [CW-1:0]    tx_cnt_r;          // Cycles left in this bit
  logic [3:0]       tx_left_r;         // Bits left to send
  wire logic        rx_tick = rx_busy_r && rx_cnt_r == '0;
  wire logic        tx_tick = tx_left_r != 4'h0 && tx_cnt_r == '0;

  assign tx_ready = tx_left_r == 4'h0;
  assign txd      = tx_sh_r[0];
  assign rx_data  = rx_sh_r;

  // Only the second stage is looked at by the framing logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd;
      rxd_s_r <= rxd_m_r;
    end
  end

  // Receive: sample mid-bit; a start that is high at mid-bit is a glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r  <= '0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_valid  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_r) begin
        if (!rxd_s_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= CW'(HALF_N - 1);
          rx_bit_r  <= 4'h0;
        end
      end else if (!rx_tick) begin
        rx_cnt_r <= rx_cnt_r - CW'(1);
      end else begin
        rx_cnt_r <= CW'(BIT_N - 1);
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rxd_s_r) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          rx_valid  <= rxd_s_r;  // Bad stop bit drops the byte [RULE_01]
        end else if (rx_bit_r != 4'h0) begin
          rx_sh_r <= {rxd_s_r, rx_sh_r[7:1]};  // [RULE_01]
        end
      end
    end
  end

  // Transmit: ten bit periods per byte, line held high between bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_r   <= 10'h3FF;
      tx_cnt_r  <= '0;
      tx_left_r <= 4'h0;
    end else if (tx_valid && tx_ready) begin
      tx_sh_r   <= {1'b1, tx_data, 1'b0};  // [RULE_01]
      tx_cnt_r  <= CW'(BIT_N - 1);
      tx_left_r <= 4'hA;
    end else if (tx_tick) begin
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      tx_cnt_r  <= CW'(BIT_N - 1);
      tx_left_r <= tx_left_r - 4'h1;
    end else if (tx_left_r != 4'h0) begin
      tx_cnt_r <= tx_cnt_r - CW'(1);
    end
  end

  // A taken byte opens with a low start bit
  tx_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
    tx_valid && tx_ready |=> !txd [*8])
    else $error("start bit not driven low");
  // The line idles high between bytes
  tx_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
    tx_ready |-> txd)
    else $error("line not high while idle");
endmodule // rsc_uart
`default_nettype wire

// ==== dv/rsc_host_model.sv ====
// Host model: sends command lines over the serial pin, collects replies.
// Assumes 8N1 framing at the package bit period on the single clock.
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model
  import rsc_pkg::*;
#(
  parameter int unsigned BIT_N = BIT_CYC  // Clock cycles per serial bit
) (
  // Clock
  input  wire logic hclk,
  // Serial pins
  output logic      txd,
  input  wire logic rxd
);
  byte unsigned rx_q[$];  // Reply bytes seen
  initial txd = 1'b1;     // Line idles high
  // One byte, start bit, LSB first, one stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= f[i];
      repeat (BIT_N) @(posedge hclk);
    end
  endtask
  // A whole line, bytes back to back
  task automatic send_line(input string s);
    foreach (s[i]) send_byte(s[i]);
  endtask
  // Receiver samples mid-bit; a low stop bit drops the byte
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge rxd);
      repeat (BIT_N / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_N) @(posedge hclk);
        b[i] = rxd;
      end
      repeat (BIT_N) @(posedge hclk);
      if (rxd === 1'b1) rx_q.push_back(b);
    end
  end
endmodule // rsc_host_model
`default_nettype wire

// ==== dv/rsc_tb_top.sv ====
// Testbench: the host model sends lines, a reference model tracks state.
// Assumes the package, the parser and the host model compile first.
`timescale 1ns/1ps
`default_nettype none
module rf_source_command_parser_tb_top
  import rsc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rxd, txd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        src_ext, osc_on, amp_en, pa_ffwd;
  logic [6:0]  atten_qdb;
  logic [11:0] freq_mhz;
  logic [7:0]  power_w;
  int          miscompares, comparisons, seed;
  // Short serial bit keeps the whole run well inside its cycle budget
  localparam int BIT_T = 16;
  // Reference model, starts at the power-on settings
  int          m_freq = 2450, m_att = 127, m_pwr, m_en, m_ext, m_ok, m_bad;

  rsc_parser #(.BIT_N(BIT_T)) rsc_parser_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .uart_rxd(rxd), .uart_txd(txd),
    .src_ext(src_ext), .osc_on(osc_on), .amp_en(amp_en), .pa_ffwd(pa_ffwd),
    .atten_qdb(atten_qdb), .freq_mhz(freq_mhz), .power_w(power_w));
  rsc_host_model #(.BIT_N(BIT_T)) rsc_host_model_i (.hclk(hclk),
    .txd(rxd), .rxd(txd));

  // Free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Verdict and end of run, also reached by any timeout
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input int exp, input string m);
    comparisons++;
    if (seen !== 32'(exp)) begin
      miscompares++;
      $display("ERROR %0t %s seen %0h exp %0h", $time, m, seen, exp);
    end
  endtask

  // One single AHB-Lite word transfer; entered just after a rising edge
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    r = hrdata;
    if (n >= 50) begin
      miscompares++;
      close_out();
    end
  endtask

  // Outputs and status word against the model
  task automatic cmp_all();
    chk(32'(freq_mhz), m_freq, "freq");
    chk(32'(power_w), m_pwr, "power");
    chk(32'(amp_en), m_en, "enable");
    chk(32'(src_ext), m_ext, "source");
    chk(32'(osc_on), m_en & !m_ext, "osc");
    chk(32'(pa_ffwd), m_ext, "ffwd");
    chk(32'(atten_qdb), m_att, "atten");
    ahb(A_STAT, 1'b0, 32'h0, rd);
    chk(rd, m_ext * 9 + (m_en & !m_ext) * 2 + m_en * 4, "status");
    ahb(A_FREQ, 1'b0, 32'h0, rd);
    chk(rd, m_freq, "freq reg");
    ahb(A_POWER, 1'b0, 32'h0, rd);
    chk(rd, m_pwr, "power reg");
    ahb(A_ATTEN, 1'b0, 32'h0, rd);
    chk(rd, m_att, "atten reg");
  endtask

  // Send one line; a good one must answer, a bad one must stay silent
  task automatic cmd(input logic [31:0] nm, input int arg, input bit good);
    string n, got;
    int k;
    n = "";
    got = "";
    for (int i = 3; i >= 0; i--)
      if (nm[8*i+:8] != 8'h00) n = $sformatf("%s%c", n, nm[8*i+:8]);
    rsc_host_model_i.rx_q.delete();
    rsc_host_model_i.send_line($sformatf("$%s,1,%0d\n", n, arg));
    for (k = 0; k < (good ? 200 : 160) * BIT_T; k++) begin
      @(posedge hclk);
      if (rsc_host_model_i.rx_q.size() > 0 &&
          rsc_host_model_i.rx_q[$] == CH_LF) break;
    end
    if (good && k == 200 * BIT_T) begin
      miscompares++;
      close_out();
    end
    // Let the reply's stop bit finish before the next line
    repeat (BIT_T) @(posedge hclk);
    foreach (rsc_host_model_i.rx_q[i])
      got = $sformatf("%s%c", got, rsc_host_model_i.rx_q[i]);
    chk(32'(got == (good ? $sformatf("$%s,1,OK\r\n", n) : "")), 1, n);
    if (good) begin
      m_ok++;
      case (nm)
        NM_FREQ: m_freq = arg;
        NM_PWR:  m_pwr = arg;
        NM_EN:   m_en = arg;
        NM_ATT:  m_att = arg;
        default: begin
          m_ext = arg;
          m_en = 0;
          if (arg == 1) m_att = 0;
        end
      endcase
    end else m_bad++;
    cmp_all();
    $display("test %s %0d done", n, arg);
  endtask

  initial begin
    seed = 37263;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    cmp_all();
    chk(32'(hresp), 0, "hresp");
    ahb(8'h20, 1'b0, 32'h0, rd);
    chk(rd, 0, "unmapped");
    cmd(NM_FREQ, 2400 + {$random(seed)} % 101, 1'b1);
    cmd(NM_PWR, {$random(seed)} % 51, 1'b1);
    cmd(NM_EN, 1, 1'b1);
    cmd(NM_EN, 0, 1'b1);
    cmd(NM_EN, 1, 1'b1);
    cmd(NM_FREQ, 2501, 1'b0);
    cmd(NM_PWR, 51, 1'b0);
    cmd(NM_SRC, 1, 1'b1);
    cmd(NM_FREQ, 2400 + {$random(seed)} % 101, 1'b1);
    cmd(NM_ATT, 8, 1'b1);
    cmd(NM_EN, 1, 1'b1);
    cmd(NM_SRC, 0, 1'b1);
    cmd(32'h0051_5253, 1, 1'b0);
    // Line acceptance off: a line is ignored and not counted
    ahb(A_CTRL, 1'b1, 32'h0, rd);
    ahb(A_CTRL, 1'b0, 32'h0, rd);
    chk(rd, 0, "ctrl");
    cmd(NM_ATT, 5, 1'b0);
    m_bad--;
    ahb(A_CTRL, 1'b1, 32'h1, rd);
    ahb(A_COUNT, 1'b0, 32'h0, rd);
    chk(rd, m_bad * 65536 + m_ok, "count");
    close_out();
  end
endmodule // rf_source_command_parser_tb_top
`default_nettype wire
